//--- receiver_serial_port.sv
// receiver end: serial slave stream port, port strap, cold start, safe boot, tx-pending pin
`timescale 1ns/1ps
`include "host_link_consts.svh"
module receiver_serial_port #(
   parameter int DEPTH       = 8,
   parameter int COLD_CYCLES = `COLD_START_MS * `CLK_KHZ,
   parameter int IDLE_CYCLES = `IDLE_TIMEOUT_MS * `CLK_KHZ
) (
   // clock and reset
   input  wire logic                           clk_sys,
   input  wire logic                           rstn,
   // link pins
   host_link_if.device                         link,
   // outgoing message stream from software
   input  wire logic                           txValid,
   input  wire logic [7:0]                     txData,
   output logic                                txReady,
   // incoming message bytes to the parser
   output logic                                rxValid,
   output logic [7:0]                          rxData,
   output logic                                parserActive,
   // tx-pending configuration
   input  wire logic                           cfgWrite,
   input  wire logic                           cfgPinOk,
   input  wire logic                           cfgEnable,
   input  wire logic                           cfgActiveHigh,
   input  wire logic [$clog2(DEPTH+1)-1:0]     cfgThreshold,
   input  wire logic                           extTimeout,
   output logic                                txpEnable,
   output logic                                txpActiveHigh,
   output logic [$clog2(DEPTH+1)-1:0]          txpThreshold,
   // status
   output host_link_pkg::link_mode_type        linkMode,
   output logic                                safeBoot,
   output logic                                coldStart,
   output logic                                portIdle
);
   localparam int CW = $clog2(DEPTH + 1);
   localparam int KW = $clog2(COLD_CYCLES + 1);
   localparam int IW = $clog2(IDLE_CYCLES + 1);
   localparam int UW = $clog2(`EXT_TX_LIMIT + 1);

   logic [5:0]     syncA;
   logic [5:0]     syncB;
   logic           sclkPrev;
   logic           csPrev;
   logic           sclkS;
   logic           csS;
   logic           mosiS;
   logic           selS;
   logic           coldS;
   logic           bootS;
   logic           linkOn;
   logic           selected;
   logic           sclkRise;
   logic           sclkFall;
   logic           csFall;
   logic           loadEvt;
   logic           loadPending;
   logic [2:0]     bitCnt;
   logic           byteDone;
   logic [7:0]     txShift;
   logic [7:0]     rxShift;
   logic [7:0]     byteIn;
   logic [5:0]     ffRun;
   logic           suspended;
   logic           fifoInReady;
   logic           fifoOutValid;
   logic [7:0]     fifoOutData;
   logic [CW-1:0]  fifoCount;
   logic           push;
   logic [1:0]     bootWait;
   logic [KW-1:0]  coldCnt;
   logic [IW-1:0]  idleCnt;
   logic           timedOut;
   logic [UW-1:0]  undelivered;
   logic           txpActive;

   // two-flop synchronisers on every pin from the host
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         syncA <= 6'h1F;                                  // clock idles low, other pins idle high
         syncB <= 6'h1F;
      end else begin
         syncA <= {link.sclk, link.csN, link.mosi, link.serialSelN, link.coldStartN, link.recoveryBootPinN};
         syncB <= syncA;
      end
   end
   assign {sclkS, csS, mosiS, selS, coldS, bootS} = syncB;

   // edge history of the clock and select
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sclkPrev <= 1'b0;
         csPrev   <= 1'b1;
      end else begin
         sclkPrev <= sclkS;
         csPrev   <= csS;
      end
   end

   // link enable and host-made edges; receiver never makes a clock
   assign linkMode = selS ? host_link_pkg::LINK_UART_I2C : host_link_pkg::LINK_SERIAL;
   assign linkOn   = !selS && !safeBoot;
   assign selected = linkOn && !csS;
   assign sclkRise = selected && sclkS && !sclkPrev;
   assign sclkFall = selected && !sclkS && sclkPrev;
   assign csFall   = linkOn && !csS && csPrev;
   assign loadEvt  = csFall || (sclkFall && loadPending);
   assign byteDone = sclkRise && (bitCnt == 3'h7);
   assign byteIn   = {rxShift[6:0], mosiS};

   // bit position and reload request between bytes
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         bitCnt      <= 3'h0;
         loadPending <= 1'b0;
      end else if (!selected) begin
         bitCnt      <= 3'h0;
         loadPending <= 1'b0;
      end else begin
         if (sclkRise) begin
            bitCnt <= bitCnt + 1'b1;
         end
         if (byteDone) begin
            loadPending <= 1'b1;
         end else if (loadEvt) begin
            loadPending <= 1'b0;
         end
      end
   end

   // outgoing shifter: next stream byte or the idle byte
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         txShift <= `IDLE_BYTE;
      end else if (loadEvt) begin
         txShift <= fifoOutValid ? fifoOutData : `IDLE_BYTE;
      end else if (sclkFall) begin
         txShift <= {txShift[6:0], 1'b1};
      end
   end
   assign link.misoOut = txShift[7];
   assign link.misoOe  = selected;

   // incoming shifter; every byte is a message byte, none is an address
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rxShift <= 8'h00;
      end else if (sclkRise) begin
         rxShift <= byteIn;
      end
   end

   // idle-byte run length and parser suspension
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ffRun     <= 6'h00;
         suspended <= 1'b0;
         rxValid   <= 1'b0;
         rxData    <= 8'h00;
      end else begin
         rxValid <= 1'b0;
         if (coldStart) begin
            ffRun     <= 6'h00;
            suspended <= 1'b0;
         end else if (byteDone) begin
            rxData  <= byteIn;
            rxValid <= !suspended || (byteIn != `IDLE_BYTE);
            if (byteIn == `IDLE_BYTE) begin
               if (ffRun != 6'(`SUSPEND_RUN)) begin
                  ffRun <= ffRun + 1'b1;
               end
               if (ffRun == 6'(`SUSPEND_RUN - 1)) begin
                  suspended <= 1'b1;
               end
            end else begin
               ffRun     <= 6'h00;
               suspended <= 1'b0;
            end
         end
      end
   end
   assign parserActive = !suspended;

   // outgoing queue; the link drains one byte per byte moved
   assign push    = txValid && !portIdle && fifoInReady;
   assign txReady = portIdle || (timedOut && extTimeout) || fifoInReady;
   stream_fifo #(
      .WIDTH (8),
      .DEPTH (DEPTH)
   ) u_tx_fifo (
      .clk_sys  (clk_sys),
      .rstn     (rstn),
      .flush    (coldStart),
      .inValid  (push),
      .inData   (txData),
      .inReady  (fifoInReady),
      .outValid (fifoOutValid),
      .outData  (fifoOutData),
      .outReady (loadEvt),
      .count    (fifoCount)
   );

   // host inactivity and undelivered-byte tally
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         idleCnt     <= '0;
         undelivered <= '0;
         timedOut    <= 1'b0;
         portIdle    <= 1'b0;
      end else if (byteDone || coldStart) begin
         idleCnt     <= '0;
         undelivered <= '0;
         timedOut    <= 1'b0;
         portIdle    <= 1'b0;
      end else begin
         if (idleCnt != IW'(IDLE_CYCLES)) begin
            idleCnt <= idleCnt + 1'b1;
         end
         timedOut <= (idleCnt == IW'(IDLE_CYCLES));
         if (txValid && txReady && undelivered != UW'(`EXT_TX_LIMIT)) begin
            undelivered <= undelivered + 1'b1;
         end
         portIdle <= timedOut && (!extTimeout || undelivered == UW'(`EXT_TX_LIMIT));
      end
   end

   // tx-pending settings, zero when the pin choice is refused
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         txpEnable     <= 1'b0;
         txpActiveHigh <= 1'b0;
         txpThreshold  <= '0;
      end else if (coldStart) begin
         txpEnable     <= 1'b0;
         txpActiveHigh <= 1'b0;
         txpThreshold  <= '0;
      end else if (cfgWrite) begin
         txpEnable     <= cfgPinOk && cfgEnable;
         txpActiveHigh <= cfgPinOk && cfgActiveHigh;
         txpThreshold  <= cfgPinOk ? cfgThreshold : '0;
      end
   end

   // tx-pending level: set at threshold, cleared once the queue is drained
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         txpActive         <= 1'b0;
         link.txPendingPin <= 1'b0;
      end else begin
         if (!txpEnable || fifoCount == '0) begin
            txpActive <= 1'b0;
         end else if (txpThreshold != '0 && fifoCount >= txpThreshold) begin
            txpActive <= 1'b1;
         end
         link.txPendingPin <= txpEnable && (txpActive ^ !txpActiveHigh);
      end
   end

   // cold start after the pin has stayed low long enough
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         coldCnt   <= '0;
         coldStart <= 1'b0;
      end else begin
         coldStart <= 1'b0;
         if (coldS) begin
            coldCnt <= '0;
         end else if (coldCnt != KW'(COLD_CYCLES)) begin
            coldCnt <= coldCnt + 1'b1;
            if (coldCnt == KW'(COLD_CYCLES - 1)) begin
               coldStart <= 1'b1;
            end
         end
      end
   end

   // boot pin caught once its synchroniser has filled after reset
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         bootWait <= 2'h0;
         safeBoot <= 1'b0;
      end else if (bootWait != 2'h3) begin
         bootWait <= bootWait + 1'b1;
         if (bootWait == 2'h2) begin
            safeBoot <= !bootS;
         end
      end
   end
endmodule : receiver_serial_port

//--- host_link_consts.svh
// constants shared by both ends of the host serial stream port
`ifndef HOST_LINK_CONSTS_SVH
`define HOST_LINK_CONSTS_SVH

`define IDLE_BYTE        8'hFF
`define TRAIN_BYTE       8'h55
`define SUSPEND_RUN      50
`define CLK_KHZ          50000
`define COLD_START_MS    100
`define IDLE_TIMEOUT_MS  2000
`define SAFE_WAIT_US     2000
`define TRAIN_BAUD       9600
`define EXT_TX_LIMIT     4096
`define TXP_TAIL_BYTES   16
`define TXP_THRESH_MAX   2048
`define SCLK_HALF_DIV    4
`define BITS_PER_BYTE    8

`endif

//--- host_link_pkg.sv
// types shared by both ends of the host serial stream port
package host_link_pkg;
   typedef enum logic {
      LINK_SERIAL,
      LINK_UART_I2C
   } link_mode_type;

   typedef enum logic [1:0] {
      MASTER_IDLE,
      MASTER_SHIFT,
      MASTER_GAP
   } master_state_type;
endpackage : host_link_pkg

//--- host_link_if.sv
// pin bundle joining the receiver end and the host end of the serial link
`timescale 1ns/1ps
interface host_link_if;
   logic sclk;
   logic csN;
   logic mosi;
   logic misoOut;
   logic misoOe;
   logic misoLine;
   logic serialSelN;
   logic coldStartN;
   logic recoveryBootPinN;
   logic txPendingPin;

   // released data-out line floats to the pull-up level
   assign misoLine = misoOe ? misoOut : 1'b1;

   modport device (
      input  sclk,
      input  csN,
      input  mosi,
      input  serialSelN,
      input  coldStartN,
      input  recoveryBootPinN,
      output misoOut,
      output misoOe,
      output txPendingPin
   );

   modport host (
      output sclk,
      output csN,
      output mosi,
      output serialSelN,
      output coldStartN,
      output recoveryBootPinN,
      input  misoLine,
      input  txPendingPin
   );
endinterface : host_link_if

//--- stream_fifo.sv
// outgoing byte queue with valid/ready on both sides and an occupancy count
`timescale 1ns/1ps
module stream_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic                       clk_sys,
   input  wire logic                       rstn,
   input  wire logic                       flush,
   // fill side
   input  wire logic                       inValid,
   input  wire logic [WIDTH-1:0]           inData,
   output logic                            inReady,
   // drain side
   output logic                            outValid,
   output logic [WIDTH-1:0]                outData,
   input  wire logic                       outReady,
   // occupancy
   output logic [$clog2(DEPTH+1)-1:0]      count
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr;
   logic [AW-1:0]    rdPtr;
   logic             push;
   logic             pop;

   // honest full and empty from the count
   assign inReady  = (count != DEPTH[$clog2(DEPTH+1)-1:0]);
   assign outValid = (count != '0);
   assign outData  = mem[rdPtr];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;

   // storage
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wrPtr] <= inData;
      end
   end

   // pointers and count
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else if (flush) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
         end
         if (pop) begin
            rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule : stream_fifo

//--- host_serial_master.sv
// host end: serial master that moves one byte each way per transfer and drives the strap pins
`timescale 1ns/1ps
`include "host_link_consts.svh"
module host_serial_master #(
   parameter int HALF_DIV    = `SCLK_HALF_DIV,
   parameter int COLD_CYCLES = `COLD_START_MS * `CLK_KHZ,
   parameter int SAFE_CYCLES = `SAFE_WAIT_US * `CLK_KHZ / 1000
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   // link pins
   host_link_if.host        link,
   // bytes to send
   input  wire logic        cmdValid,
   input  wire logic [7:0]  cmdData,
   output logic             cmdReady,
   input  wire logic        pollEnable,
   // bytes received, idle bytes removed
   output logic             rxValid,
   output logic [7:0]       rxData,
   // strap and reset control
   input  wire logic        serialSelN,
   input  wire logic        recoveryBootReqN,
   input  wire logic        coldStartReq,
   input  wire logic        trainSent,
   output logic             uartHold,
   output logic             txPending
);
   localparam int HW = $clog2(HALF_DIV + 1);
   localparam int KW = $clog2(COLD_CYCLES + 1);
   localparam int SW = $clog2(SAFE_CYCLES + 1);

   host_link_pkg::master_state_type state;
   logic [HW-1:0] halfCnt;
   logic [2:0]    bitCnt;
   logic [7:0]    txShift;
   logic [7:0]    rxShift;
   logic          halfDone;
   logic [KW-1:0] coldCnt;
   logic [SW-1:0] safeCnt;

   // straps and the pending indicator pass straight through
   assign link.serialSelN       = serialSelN;
   assign link.recoveryBootPinN = recoveryBootReqN;
   assign txPending             = link.txPendingPin;
   assign link.mosi             = txShift[7];
   assign cmdReady              = (state == host_link_pkg::MASTER_IDLE);
   assign halfDone              = (halfCnt == HW'(HALF_DIV - 1));

   // transfer sequencer with divided serial clock
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state     <= host_link_pkg::MASTER_IDLE;
         halfCnt   <= '0;
         bitCnt    <= 3'h0;
         txShift   <= `IDLE_BYTE;
         rxShift   <= 8'h00;
         link.sclk <= 1'b0;
         link.csN  <= 1'b1;
         rxValid   <= 1'b0;
         rxData    <= 8'h00;
      end else begin
         rxValid <= 1'b0;
         halfCnt <= halfDone ? '0 : halfCnt + 1'b1;
         unique case (state)
            host_link_pkg::MASTER_IDLE: begin
               halfCnt <= '0;
               if (cmdValid || pollEnable) begin
                  txShift  <= cmdValid ? cmdData : `IDLE_BYTE;
                  bitCnt   <= 3'h0;
                  link.csN <= 1'b0;
                  state    <= host_link_pkg::MASTER_SHIFT;
               end
            end
            host_link_pkg::MASTER_SHIFT: begin
               if (halfDone) begin
                  if (!link.sclk) begin
                     link.sclk <= 1'b1;
                     rxShift   <= {rxShift[6:0], link.misoLine};
                  end else begin
                     link.sclk <= 1'b0;
                     bitCnt    <= bitCnt + 1'b1;
                     txShift   <= {txShift[6:0], 1'b1};
                     if (bitCnt == 3'h7) begin
                        link.csN <= 1'b1;
                        rxData   <= rxShift;
                        rxValid  <= (rxShift != `IDLE_BYTE);
                        state    <= host_link_pkg::MASTER_GAP;
                     end
                  end
               end
            end
            host_link_pkg::MASTER_GAP: begin
               if (halfDone) begin
                  state <= host_link_pkg::MASTER_IDLE;
               end
            end
         endcase
      end
   end

   // cold start pin held low for the full period
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         coldCnt         <= '0;
         link.coldStartN <= 1'b1;
      end else if (coldStartReq && link.coldStartN) begin
         coldCnt         <= '0;
         link.coldStartN <= 1'b0;
      end else if (!link.coldStartN) begin
         coldCnt <= coldCnt + 1'b1;
         if (coldCnt == KW'(COLD_CYCLES)) begin
            link.coldStartN <= 1'b1;
         end
      end
   end

   // quiet gap after the safe-boot training bytes
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         safeCnt  <= '0;
         uartHold <= 1'b0;
      end else if (trainSent) begin
         safeCnt  <= '0;
         uartHold <= 1'b1;
      end else if (uartHold) begin
         safeCnt <= safeCnt + 1'b1;
         if (safeCnt == SW'(SAFE_CYCLES)) begin
            uartHold <= 1'b0;
         end
      end
   end
endmodule : host_serial_master

//--- host_spi_stream_monitor.sv
// concurrent checks on the serial link pins between the host end and the receiver end
`timescale 1ns/1ps
`include "host_link_consts.svh"
module host_spi_stream_monitor #(
   parameter int COLD_CYCLES = `COLD_START_MS * `CLK_KHZ
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // link pins
   input wire logic sclk,
   input wire logic csN,
   input wire logic mosi,
   input wire logic misoOe,
   input wire logic misoLine,
   input wire logic serialSelN,
   input wire logic coldStartN,
   input wire logic txPendingPin
);
   localparam int LW = $clog2(COLD_CYCLES + 2);
   logic [LW-1:0] lowCnt;
   logic [2:0] upCnt;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // length of the present low run on the cold start pin
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn)
         lowCnt <= '0;
      else if (coldStartN)
         lowCnt <= '0;
      else if (lowCnt != '1)
         lowCnt <= lowCnt + 1'b1;
   end
   // cycles since reset release, saturating
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn)
         upCnt <= 3'h0;
      else if (upCnt != 3'h7)
         upCnt <= upCnt + 3'h1;
   end
   // data bit held over the sampling rise and the cycles after it
   sequence s_bitHeld;
      $stable(mosi) ##1 $stable(mosi)[*3];
   endsequence
   property p_clkInFrame; $changed(sclk) |-> !csN || $rose(csN); endproperty
   a_clkInFrame: assert property (p_clkInFrame) else $error("serial clock moved outside a frame");
   property p_halfPeriod; $changed(sclk) |=> $stable(sclk)[*3]; endproperty
   a_halfPeriod: assert property (p_halfPeriod) else $error("serial clock half period too short");
   property p_mosiSetup; $rose(sclk) |-> s_bitHeld; endproperty
   a_mosiSetup: assert property (p_mosiSetup) else $error("host data moved near a rising clock");
   property p_releaseDeselect; csN[*6] |-> !misoOe; endproperty
   a_releaseDeselect: assert property (p_releaseDeselect) else $error("data out driven while deselected");
   property p_releaseStrap; serialSelN[*6] |-> !misoOe && misoLine; endproperty
   a_releaseStrap: assert property (p_releaseStrap) else $error("data out driven in uart mode");
   property p_driveAfterSelect; $rose(misoOe) |-> !csN && !serialSelN && !$past(csN, 2); endproperty
   a_driveAfterSelect: assert property (p_driveAfterSelect) else $error("data out driven too early");
   property p_coldLength; $rose(coldStartN) |-> lowCnt >= COLD_CYCLES; endproperty
   a_coldLength: assert property (p_coldLength) else $error("cold start pulse too short");
   property p_pendAfterReset; upCnt < 3'h4 |-> !txPendingPin; endproperty
   a_pendAfterReset: assert property (p_pendAfterReset) else $error("pending pin active after reset");
endmodule : host_spi_stream_monitor

//--- tb_host_spi_stream_port.sv
// self-checking bench: host end and receiver end joined over the serial link
`timescale 1ns/1ps
module tb_host_spi_stream_port;
   logic       clk_sys = 1'b0, rstn = 1'b0, txValid = 1'b0, cmdValid = 1'b0, pollEnable = 1'b0;
   logic       selN = 1'b0, coldReq = 1'b0, cfgWrite = 1'b0, cfgPinOk = 1'b0, cfgEnable = 1'b0;
   logic       cfgActiveHigh = 1'b0, txReady, devRxValid, parserActive, txpEnable, coldStart;
   logic       portIdle, cmdReady, hostRxValid, txPending;
   logic       extTimeout = 1'b0, trainSent = 1'b0, txpActiveHigh, safeBoot, uartHold;
   logic [3:0] cfgThreshold = 4'h0, txpThreshold;
   logic [7:0] txData = 8'h00, cmdData = 8'h00, devRxData, hostRxData, b;
   logic [7:0] hostExp[$], devExp[$];
   int         fails = 0, checks = 0, devFf = 0, i;
   host_link_pkg::link_mode_type linkMode;
   host_link_if host_link_if_i();
   receiver_serial_port #(.COLD_CYCLES(50), .IDLE_CYCLES(200)) receiver_serial_port_i (
      .clk_sys(clk_sys), .rstn(rstn), .link(host_link_if_i), .txValid(txValid), .txData(txData),
      .txReady(txReady), .rxValid(devRxValid), .rxData(devRxData), .parserActive(parserActive),
      .cfgWrite(cfgWrite), .cfgPinOk(cfgPinOk), .cfgEnable(cfgEnable), .cfgActiveHigh(cfgActiveHigh),
      .cfgThreshold(cfgThreshold), .extTimeout(extTimeout), .txpEnable(txpEnable), .txpActiveHigh(txpActiveHigh),
      .txpThreshold(txpThreshold), .linkMode(linkMode), .safeBoot(safeBoot), .coldStart(coldStart),
      .portIdle(portIdle));
   host_serial_master #(.COLD_CYCLES(50), .SAFE_CYCLES(20)) host_serial_master_i (
      .clk_sys(clk_sys), .rstn(rstn), .link(host_link_if_i), .cmdValid(cmdValid), .cmdData(cmdData),
      .cmdReady(cmdReady), .pollEnable(pollEnable), .rxValid(hostRxValid), .rxData(hostRxData),
      .serialSelN(selN), .recoveryBootReqN(1'b1), .coldStartReq(coldReq), .trainSent(trainSent),
      .uartHold(uartHold), .txPending(txPending));
   host_spi_stream_monitor #(.COLD_CYCLES(50)) host_spi_stream_monitor_i (
      .clk_sys(clk_sys), .rstn(rstn), .sclk(host_link_if_i.sclk), .csN(host_link_if_i.csN),
      .mosi(host_link_if_i.mosi), .misoOe(host_link_if_i.misoOe), .misoLine(host_link_if_i.misoLine),
      .serialSelN(host_link_if_i.serialSelN), .coldStartN(host_link_if_i.coldStartN),
      .txPendingPin(host_link_if_i.txPendingPin));
   always #10 clk_sys = ~clk_sys;
   task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic report_and_stop;
      if (fails == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : report_and_stop
   // one host write; a byte comes back in the same transfer
   task automatic send(input logic [7:0] v);
      @(negedge clk_sys);
      cmdValid = 1'b1;
      cmdData = v;
      while (cmdReady !== 1'b1) @(negedge clk_sys);
      @(negedge clk_sys);
      cmdValid = 1'b0;
      while (cmdReady !== 1'b1) @(negedge clk_sys);
   endtask : send
   task automatic sendRand;
      b = 8'($urandom_range(0, 254));
      devExp.push_back(b);
      send(b);
   endtask : sendRand
   task automatic cfg(input logic ok, input logic en, input logic hi, input logic [3:0] th);
      @(negedge clk_sys);
      {cfgWrite, cfgPinOk, cfgEnable, cfgActiveHigh, cfgThreshold} = {1'b1, ok, en, hi, th};
      @(negedge clk_sys);
      cfgWrite = 1'b0;
      repeat (3) @(negedge clk_sys);
   endtask : cfg
   task automatic poll(input int n);
      pollEnable = 1'b1;
      repeat (n) @(negedge clk_sys);
      pollEnable = 1'b0;
      while (cmdReady !== 1'b1) @(negedge clk_sys);
   endtask : poll
   // compare every delivered byte with the oldest note; idle bytes at the receiver are counted
   always @(negedge clk_sys) begin
      if (hostRxValid === 1'b1)
         chk("hostRx", hostExp.size() ? {1'b0, hostExp.pop_front()} : 9'h100, hostRxData);
      if (devRxValid === 1'b1 && devRxData === 8'hFF)
         devFf++;
      else if (devRxValid === 1'b1)
         chk("devRx", devExp.size() ? {1'b0, devExp.pop_front()} : 9'h100, devRxData);
   end
   // cut a hang short
   initial begin
      #1000000;
      fails++;
      report_and_stop();
   end
   // main sequence
   initial begin
      void'($urandom(32'h37A2));
      repeat (12) @(negedge clk_sys);
      rstn = 1'b1;
      repeat (4) @(negedge clk_sys);
      chk("pendOff", 1'b0, txPending);
      chk("safeOff", 1'b0, safeBoot);
      cfg(1'b1, 1'b1, 1'b1, 4'h4);
      chk("thresh", 9'h004, txpThreshold);
      for (i = 0; i < 12; i++) begin
         @(negedge clk_sys);
         txValid = txReady;
         txData = 8'($urandom_range(0, 254));
         if (txReady === 1'b1)
            hostExp.push_back(txData);
      end
      chk("full", 9'h008, 9'(hostExp.size()));
      chk("pendOn", 1'b1, txPending);
      pollEnable = 1'b1;
      for (i = 0; i < 9000 && parserActive !== 1'b0; i++) @(negedge clk_sys);
      poll(400);
      chk("ffRun", 9'h032, 9'(devFf));
      chk("drained", 9'h000, 9'(hostExp.size()));
      chk("pendDone", 1'b0, txPending);
      for (i = 0; i < 3; i++) sendRand();
      chk("resume", 1'b1, parserActive);
      cfg(1'b1, 1'b1, 1'b1, 4'h1);
      @(negedge clk_sys);
      txValid = 1'b1;
      txData = 8'h5A;
      @(negedge clk_sys);
      txValid = 1'b0;
      coldReq = 1'b1;
      @(negedge clk_sys);
      coldReq = 1'b0;
      for (i = 0; i < 200 && coldStart !== 1'b1; i++) @(negedge clk_sys);
      chk("coldLate", 1'b1, i >= 48);
      repeat (3) @(negedge clk_sys);
      chk("coldCfg", 9'h000, {txpEnable, txpThreshold, txPending});
      poll(300);
      selN = 1'b1;
      repeat (4) @(negedge clk_sys);
      chk("modeUart", host_link_pkg::LINK_UART_I2C, linkMode);
      send(8'h3C);
      selN = 1'b0;
      repeat (4) @(negedge clk_sys);
      chk("modeSerial", host_link_pkg::LINK_SERIAL, linkMode);
      cfg(1'b1, 1'b1, 1'b0, 4'h4);
      chk("lowActive", 9'h001, {txpActiveHigh, txPending});
      cfg(1'b0, 1'b1, 1'b1, 4'h4);
      chk("badPin", 9'h000, {txpEnable, txpThreshold, txPending});
      trainSent = 1'b1;
      @(negedge clk_sys);
      trainSent = 1'b0;
      @(negedge clk_sys);
      chk("hold", 1'b1, uartHold);
      repeat (20) @(negedge clk_sys);
      chk("holdEnd", 1'b0, uartHold);
      sendRand();
      repeat (150) @(negedge clk_sys);
      chk("notIdle", 1'b0, portIdle);
      for (i = 0; i < 150 && portIdle !== 1'b1; i++) @(negedge clk_sys);
      chk("idle", 1'b1, portIdle);
      sendRand();
      chk("awake", 1'b0, portIdle);
      repeat (20) @(negedge clk_sys);
      chk("left", 9'h000, 9'(hostExp.size() + devExp.size()));
      // extended timeout: no idling until the undelivered tally is full
      extTimeout = 1'b1;
      txValid = 1'b1;
      for (i = 0; i < 5000 && portIdle !== 1'b1; i++) begin
         @(negedge clk_sys);
         txData = 8'($urandom);
      end
      txValid = 1'b0;
      chk("extIdle", 1'b1, portIdle === 1'b1 && i > 3800);
      report_and_stop();
   end
endmodule : tb_host_spi_stream_port
